// [logic/io_common_cfg.svh]
`ifndef IO_COMMON_CFG_SVH
`define IO_COMMON_CFG_SVH

// ****************************************************************
// Register offsets (byte addresses on the plain register port)
// ****************************************************************
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4

// ****************************************************************
// Control register fields and reset value
// ****************************************************************
`define CTRL_OVR_BIT 0
`define CTRL_LU_LSB 1
`define CTRL_LU_MSB 3
`define CTRL_RESET 32'h0000_0000

// ****************************************************************
// Status register fields
// ****************************************************************
`define ST_PHASE_LSB 0
`define ST_PHASE_MSB 3
`define ST_SEL_LSB 4
`define ST_SEL_MSB 6
`define ST_INVALID_BIT 7
`define ST_CC0_BIT 8
`define ST_CC1_BIT 9
`define ST_CCZ_BIT 10
`define ST_END_BIT 11
`define ST_SWCC_LSB 12
`define ST_SWCC_MSB 13

`endif

// [logic/io_common_pkg.sv]
`default_nettype none
package io_common_pkg;

   // ****************************************************************
   // Types
   // ****************************************************************
   // Phase generator states, one-hot
   typedef enum logic [4:0] {
      PH_IDLE = 5'b00001,
      PH_A = 5'b00010,
      PH_B = 5'b00100,
      PH_C = 5'b01000,
      PH_D = 5'b10000
   } phase_t;

   // End-of-execute sequencer states, one-hot
   typedef enum logic [4:0] {
      CS_IDLE = 5'b00001,
      CS_WAIT = 5'b00010,
      CS_GATE = 5'b00100,
      CS_CLR_CC = 5'b01000,
      CS_CLR_END = 5'b10000
   } cc_seq_t;

   typedef logic [2:0] chan_sel_t;

   // ****************************************************************
   // Address decode helpers; addr[2] is bit 21, addr[0] is bit 23
   // ****************************************************************
   function automatic logic addr_invalid(input logic [2:0] addr);
      addr_invalid = addr[2] | (addr[1] & addr[0]);
   endfunction : addr_invalid

   function automatic chan_sel_t chan_decode(input logic [2:0] addr);
      chan_decode = 3'h0;
      if (!addr_invalid(addr)) begin
         chan_decode[addr[1:0]] = 1'b1;
      end
   endfunction : chan_decode

endpackage : io_common_pkg
`default_nettype wire

// [logic/io_phase_if.sv]
`timescale 1ns/10ps
`default_nettype none
// Phase strobes shared by every channel
interface io_phase_if;
   logic pa;
   logic pb;
   logic pc;
   logic pd;
   logic a_entry;
   modport gen (output pa, output pb, output pc, output pd, output a_entry);
   modport use_ph (input pa, input pb, input pc, input pd, input a_entry);
endinterface : io_phase_if
`default_nettype wire

// [logic/io_phase_clock.sv]
`timescale 1ns/10ps
`default_nettype none
module io_phase_clock
   import io_common_pkg::*;
(
   input wire logic clk,
   input wire logic rst_n,
   input wire logic power_good,
   input wire logic cpu_pulse,
   io_phase_if.gen ph
);

   phase_t state_reg;
   phase_t state_next;
   logic a_entry_reg;

   // pulse-driven ring, start, B at pulse end, succession, loop
   always_comb begin
      state_next = state_reg;
      unique case (state_reg)
         PH_IDLE: state_next = cpu_pulse ? PH_A : PH_IDLE;
         PH_A: state_next = cpu_pulse ? PH_A : PH_B;
         PH_B: state_next = PH_C;
         PH_C: state_next = PH_D;
         PH_D: state_next = cpu_pulse ? PH_A : PH_IDLE;
         default: state_next = PH_IDLE;
      endcase
      if (!power_good) begin
         state_next = PH_IDLE;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg <= PH_IDLE;
         a_entry_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         a_entry_reg <= (state_next == PH_A) && (state_reg != PH_A);
      end
   end

   assign ph.pa = (state_reg == PH_A);
   assign ph.pb = (state_reg == PH_B);
   assign ph.pc = (state_reg == PH_C);
   assign ph.pd = (state_reg == PH_D);
   assign ph.a_entry = a_entry_reg;

   sequence b_entry_s;
      ph.pa && !cpu_pulse && power_good;
   endsequence

   sequence bcd_s;
      ph.pb ##1 ph.pc ##1 ph.pd;
   endsequence

   phase_onehot_a: assert property (@(posedge clk) disable iff (!rst_n) $onehot(state_reg))
      else $error("phase state not one-hot");
   phase_start_a: assert property (@(posedge clk) disable iff (!rst_n)
      (state_reg == PH_IDLE && power_good && cpu_pulse) |=> ph.pa && a_entry_reg)
      else $error("phase A did not start");
   phase_order_a: assert property (@(posedge clk) disable iff (!rst_n || !power_good)
      b_entry_s |=> bcd_s)
      else $error("phase B C D order broken");
   phase_hold_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ph.pa && cpu_pulse && power_good) |=> ph.pa && !ph.pb)
      else $error("phase B set while pulse high");
   phase_loop_a: assert property (@(posedge clk) disable iff (!rst_n)
      (ph.pd && power_good && cpu_pulse) |=> ph.pa)
      else $error("phase D did not loop to A");
   phase_stop_a: assert property (@(posedge clk) disable iff (!rst_n)
      !power_good |=> state_reg == PH_IDLE)
      else $error("phases run without power good");

endmodule : io_phase_clock
`default_nettype wire

// [logic/io_channel_decoder.sv]
`timescale 1ns/10ps
`default_nettype none
module io_channel_decoder
   import io_common_pkg::*;
(
   input wire logic [2:0] breg_bits,
   input wire logic [2:0] load_unit,
   input wire logic initial_program_load,
   output logic [2:0] addr_used,
   output chan_sel_t sel,
   output logic invalid
);

   // instruction source, load-unit source during initial load
   assign addr_used = initial_program_load ? load_unit : breg_bits;

   assign invalid = addr_invalid(addr_used);

   // decode map, nothing selected when invalid
   assign sel = chan_decode(addr_used);

endmodule : io_channel_decoder
`default_nettype wire

// [logic/io_channel_common_control.sv]
// Decided for this implementation: the address map and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "io_common_cfg.svh"
module io_channel_common_control
   import io_common_pkg::*;
(
   input wire logic MCLK,
   input wire logic RESETN,
   input wire logic POWER_GOOD,
   input wire logic CPU_CLOCK_PULSE,
   input wire logic CPU_CYCLE_PULSE2,
   input wire logic IO_INSTR_START,
   input wire logic [2:0] B_REG_BITS,
   input wire logic INITIAL_PROGRAM_LOAD,
   input wire logic [2:0] UNIT_LOAD_SWITCHES,
   input wire logic FORCE_STATUS_WORD_LOAD_LATCH,
   input wire logic CHAN_CC_SET,
   input wire logic [1:0] CHAN_CC,
   input wire logic [3:0] REG_ADDR,
   input wire logic [31:0] REG_WDATA,
   input wire logic REG_WR,
   input wire logic REG_RD,
   output logic PHASE_A,
   output logic PHASE_B,
   output logic PHASE_C,
   output logic PHASE_D,
   output logic [2:0] CHANNEL_SELECT,
   output logic ADDRESS_INVALID,
   output logic IO_TERMINATE,
   output logic END_EXECUTE,
   output logic [1:0] PROCESSOR_STATUS_WORD_CC,
   output logic PROCESSOR_STATUS_WORD_CC_LOAD,
   output logic CHAN_EXEC_CLEAR,
   output logic [31:0] REG_RDATA
);

   // ****************************************************************
   // Phase generator
   // ****************************************************************
   io_phase_if ph ();

   io_phase_clock u_phase (
      .clk(MCLK),
      .rst_n(RESETN),
      .power_good(POWER_GOOD),
      .cpu_pulse(CPU_CLOCK_PULSE),
      .ph(ph.gen)
   );

   assign PHASE_A = ph.pa;
   assign PHASE_B = ph.pb;
   assign PHASE_C = ph.pc;
   assign PHASE_D = ph.pd;

   // ****************************************************************
   // Register port
   // ****************************************************************
   logic [31:0] ctrl_reg;
   logic [31:0] rdata_reg;
   logic [31:0] status_w;
   logic wr_ctrl;
   logic rd_ctrl;
   logic rd_status;
   logic lu_override;
   logic [2:0] lu_soft;

   // Address decode for the two words; other offsets read zero
   assign wr_ctrl = REG_WR && (REG_ADDR == `REG_CTRL);
   assign rd_ctrl = REG_RD && (REG_ADDR == `REG_CTRL);
   assign rd_status = REG_RD && (REG_ADDR == `REG_STATUS);
   assign lu_override = ctrl_reg[`CTRL_OVR_BIT];
   assign lu_soft = ctrl_reg[`CTRL_LU_MSB:`CTRL_LU_LSB];

   // Control word; unused bits stay zero so they read back as zero
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         ctrl_reg <= `CTRL_RESET;
      end else if (wr_ctrl) begin
         ctrl_reg <= {28'h0, REG_WDATA[`CTRL_LU_MSB:0]};
      end
   end

   // Read data stand for exactly one cycle after the strobe
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= 32'h0;
      end else if (rd_ctrl) begin
         rdata_reg <= ctrl_reg;
      end else if (rd_status) begin
         rdata_reg <= status_w;
      end else begin
         rdata_reg <= 32'h0;
      end
   end

   assign REG_RDATA = rdata_reg;

   // ****************************************************************
   // Channel address decode
   // ****************************************************************
   logic [2:0] lu_value;
   logic [2:0] addr_used;
   chan_sel_t sel_w;
   logic invalid_w;
   chan_sel_t sel_reg;
   logic invalid_reg;
   logic term_reg;
   logic end_reg;
   logic end_clear;

   // Software may stand in for the console switches, e.g. on a bench without a panel
   assign lu_value = lu_override ? lu_soft : UNIT_LOAD_SWITCHES;

   io_channel_decoder u_decode (
      .breg_bits(B_REG_BITS),
      .load_unit(lu_value),
      .initial_program_load(INITIAL_PROGRAM_LOAD),
      .addr_used(addr_used),
      .sel(sel_w),
      .invalid(invalid_w)
   );

   // select captured at start, dropped when the instruction ends
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         sel_reg <= 3'h0;
         invalid_reg <= 1'b0;
         term_reg <= 1'b0;
      end else begin
         term_reg <= IO_INSTR_START && invalid_w;
         if (IO_INSTR_START) begin
            sel_reg <= sel_w;
            invalid_reg <= invalid_w;
         end else if (end_clear) begin
            sel_reg <= 3'h0;
         end
      end
   end

   assign CHANNEL_SELECT = sel_reg;
   assign ADDRESS_INVALID = invalid_reg;
   assign IO_TERMINATE = term_reg;

   // ****************************************************************
   // Condition code latches and end of execute
   // ****************************************************************
   logic cc_b0_reg;
   logic cc_b1_reg;
   logic cc_z_reg;
   logic [1:0] swcc_reg;
   logic any_cc;
   logic inhibit;
   logic end_set;
   logic gate;
   logic cc_clear;
   cc_seq_t seq_reg;
   cc_seq_t seq_next;

   assign any_cc = cc_b0_reg | cc_b1_reg | cc_z_reg;
   // no end during initial load before the force-load latch
   assign inhibit = INITIAL_PROGRAM_LOAD && !FORCE_STATUS_WORD_LOAD_LATCH;
   // end latch sets at phase B of cycle pulse 2
   assign end_set = (seq_reg == CS_WAIT) && ph.pb && CPU_CYCLE_PULSE2 && !inhibit;
   assign gate = (seq_reg == CS_GATE) && (ph.pc || ph.pd);
   // code latches clear at next A and D
   assign cc_clear = (seq_reg == CS_CLR_CC) && (ph.pa || ph.pd);
   // end latch clears at following D
   assign end_clear = (seq_reg == CS_CLR_END) && ph.pd;

   // Sequencer leaves its gate and clear steps only at D so the CPU always sees a full C-D window
   always_comb begin
      seq_next = seq_reg;
      unique case (seq_reg)
         CS_IDLE: seq_next = any_cc ? CS_WAIT : CS_IDLE;
         CS_WAIT: seq_next = end_set ? CS_GATE : CS_WAIT;
         CS_GATE: seq_next = ph.pd ? CS_CLR_CC : CS_GATE;
         CS_CLR_CC: seq_next = (ph.pd && !ph.a_entry) ? CS_CLR_END : CS_CLR_CC;
         CS_CLR_END: seq_next = ph.pd ? CS_IDLE : CS_CLR_END;
         default: seq_next = CS_IDLE;
      endcase
   end

   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         seq_reg <= CS_IDLE;
      end else begin
         seq_reg <= seq_next;
      end
   end

   // any channel loads the code; bit latch 0 is the high bit, a new code wins over clear
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         cc_b0_reg <= 1'b0;
         cc_b1_reg <= 1'b0;
         cc_z_reg <= 1'b0;
      end else if (CHAN_CC_SET) begin
         cc_b0_reg <= CHAN_CC[1];
         cc_b1_reg <= CHAN_CC[0];
         cc_z_reg <= (CHAN_CC == 2'h0);
      end else if (cc_clear) begin
         cc_b0_reg <= 1'b0;
         cc_b1_reg <= 1'b0;
         cc_z_reg <= 1'b0;
      end
   end

   // end latch follows any code latch, set wins over clear
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         end_reg <= 1'b0;
      end else if (end_set) begin
         end_reg <= 1'b1;
      end else if (end_clear) begin
         end_reg <= 1'b0;
      end
   end

   // copy to status word bits 02 and 03
   always_ff @(posedge MCLK or negedge RESETN) begin
      if (!RESETN) begin
         swcc_reg <= 2'h0;
      end else if (gate) begin
         swcc_reg <= {cc_b0_reg, cc_b1_reg};
      end
   end

   assign END_EXECUTE = end_reg;
   assign PROCESSOR_STATUS_WORD_CC = swcc_reg;
   assign PROCESSOR_STATUS_WORD_CC_LOAD = gate;
   assign CHAN_EXEC_CLEAR = gate;

   // ****************************************************************
   // Status word
   // ****************************************************************
   always_comb begin
      status_w = 32'h0;
      status_w[`ST_PHASE_MSB:`ST_PHASE_LSB] = {ph.pd, ph.pc, ph.pb, ph.pa};
      status_w[`ST_SEL_MSB:`ST_SEL_LSB] = sel_reg;
      status_w[`ST_INVALID_BIT] = invalid_reg;
      status_w[`ST_CC0_BIT] = cc_b0_reg;
      status_w[`ST_CC1_BIT] = cc_b1_reg;
      status_w[`ST_CCZ_BIT] = cc_z_reg;
      status_w[`ST_END_BIT] = end_reg;
      status_w[`ST_SWCC_MSB:`ST_SWCC_LSB] = swcc_reg;
   end

   // ****************************************************************
   // Checks
   // ****************************************************************
   sequence gate_window_s;
      gate && ph.pc ##1 gate && ph.pd;
   endsequence

   dec_invalid_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && invalid_w) |=> (CHANNEL_SELECT == 3'h0) && IO_TERMINATE)
      else $error("invalid address still selected");
   dec_pattern_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && (addr_used[2] || (addr_used[1:0] == 2'h3))) |=> ADDRESS_INVALID)
      else $error("invalid pattern not flagged");
   dec_onehot_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && !invalid_w) |=> $onehot(CHANNEL_SELECT) && !IO_TERMINATE)
      else $error("valid address not one channel");
   dec_map_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && !INITIAL_PROGRAM_LOAD && !invalid_w)
      |=> CHANNEL_SELECT == (3'h1 << $past(B_REG_BITS)))
      else $error("channel map wrong");
   end_phase_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      $rose(END_EXECUTE) |-> $past(ph.pb) && $past(CPU_CYCLE_PULSE2))
      else $error("end latch set outside phase B");
   ipl_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      $rose(END_EXECUTE) |-> !$past(inhibit))
      else $error("end latch set during held initial load");
   cc_copy_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (end_set && POWER_GOOD) |=> gate_window_s
      ##1 PROCESSOR_STATUS_WORD_CC == {$past(cc_b0_reg, 2), $past(cc_b1_reg, 2)})
      else $error("code not copied during C and D");
   end_clear_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (end_clear && !end_set) |=> !END_EXECUTE && seq_reg == CS_IDLE)
      else $error("end latch not cleared");
   cc_load_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      CHAN_CC_SET |=> {cc_b0_reg, cc_b1_reg} == $past(CHAN_CC) && any_cc)
      else $error("code latch pair wrong");

   // ****************************************************************
   // Checks across decode and end of execute
   // ****************************************************************
   // A terminated start must leave nothing selected for the channels
   term_sel_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      IO_TERMINATE |-> (CHANNEL_SELECT == 3'h0) && ADDRESS_INVALID)
      else $error("terminate with a channel selected");
   sel_onehot0_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      $onehot0(CHANNEL_SELECT))
      else $error("more than one channel selected");
   breg_invalid_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && !INITIAL_PROGRAM_LOAD && (B_REG_BITS == 3'h3)) |=> ADDRESS_INVALID && IO_TERMINATE)
      else $error("both low bits set not refused");
   load_chan2_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && INITIAL_PROGRAM_LOAD && (lu_value == 3'h2)) |=> CHANNEL_SELECT == 3'h4)
      else $error("load switches not used for decode");
   load_bit21_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (IO_INSTR_START && INITIAL_PROGRAM_LOAD && lu_value[2]) |=> ADDRESS_INVALID && (CHANNEL_SELECT == 3'h0))
      else $error("high address bit not refused");
   // A rising end must come from a loaded code and open the C-D gate at once
   end_code_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      $rose(END_EXECUTE) |-> $past(any_cc))
      else $error("end latch set without a code");
   end_gate_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      ($rose(END_EXECUTE) && $past(POWER_GOOD)) |-> PROCESSOR_STATUS_WORD_CC_LOAD && PHASE_C)
      else $error("end latch not followed by gate at C");
   end_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (END_EXECUTE && !end_clear) |=> END_EXECUTE)
      else $error("end latch dropped early");
   // The status word code may only move while the gate is open
   cc_hold_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      !PROCESSOR_STATUS_WORD_CC_LOAD |=> $stable(PROCESSOR_STATUS_WORD_CC))
      else $error("status word code moved outside gate");
   gate_len_a: assert property (@(posedge MCLK) disable iff (!RESETN || !POWER_GOOD)
      $rose(PROCESSOR_STATUS_WORD_CC_LOAD) |=> PROCESSOR_STATUS_WORD_CC_LOAD ##1 !PROCESSOR_STATUS_WORD_CC_LOAD)
      else $error("gate not exactly two cycles");
   cc_clear_a: assert property (@(posedge MCLK) disable iff (!RESETN)
      (cc_clear && !CHAN_CC_SET) |=> !any_cc)
      else $error("code latches not cleared");

endmodule : io_channel_common_control
`default_nettype wire

// [test/io_cpu_pulse_model.sv]
`timescale 1ns/10ps
`default_nettype none
// ****************************************************************
// CPU basic clock source driving the phase ring
// ****************************************************************
module io_cpu_pulse_model (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic run,
   input wire logic [3:0] hi_len,
   output logic pulse,
   output logic pulse2
);
   logic [3:0] cnt_reg;
   logic p2_reg;

   // High for hi_len cycles, then three low ones so B, C and D fit between pulses
   assign pulse = run & (cnt_reg < hi_len);
   assign pulse2 = p2_reg;

   // Free counter; pulse2 flips each period so only every other ring may end an instruction
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg <= 4'h0;
         p2_reg <= 1'b0;
      end else if (cnt_reg >= hi_len + 4'h2) begin
         cnt_reg <= 4'h0;
         p2_reg <= ~p2_reg;
      end else begin
         cnt_reg <= cnt_reg + 4'h1;
      end
   end
endmodule : io_cpu_pulse_model
`default_nettype wire

// [test/io_channel_common_control_bench.sv]
`timescale 1ns/10ps
`default_nettype none
module io_channel_common_control_bench;
   // ****************************************************************
   // Stimulus and observed signals
   // ****************************************************************
   logic mclk = 1'b0;
   logic resetn = 1'b0;
   logic pg = 1'b0;
   logic start = 1'b0;
   logic init_load = 1'b0;
   logic force_ld = 1'b0;
   logic cc_set = 1'b0;
   logic wr = 1'b0;
   logic rd = 1'b0;
   logic run = 1'b0;
   logic [2:0] breg = 3'h0;
   logic [2:0] lus = 3'h0;
   logic [1:0] cc = 2'h0;
   logic [3:0] addr = 4'h0;
   logic [3:0] hi = 4'h1;
   logic [31:0] wdata = 32'h0;
   logic pulse, p2, pa, pb, pc, pd, inv, term, endx, swcc_ld, xclr, prev;
   logic [2:0] sel;
   logic [1:0] swcc;
   logic [31:0] rdata;
   int fails = 0;
   int n_compared = 0;

   // Free running clock, 5 ns period
   always #2.5 mclk = ~mclk;

   io_cpu_pulse_model cpu (.clk(mclk), .rst_n(resetn), .run(run), .hi_len(hi), .pulse(pulse), .pulse2(p2));

   io_channel_common_control dut (.MCLK(mclk), .RESETN(resetn), .POWER_GOOD(pg), .CPU_CLOCK_PULSE(pulse),
      .CPU_CYCLE_PULSE2(p2), .IO_INSTR_START(start), .B_REG_BITS(breg), .INITIAL_PROGRAM_LOAD(init_load),
      .UNIT_LOAD_SWITCHES(lus), .FORCE_STATUS_WORD_LOAD_LATCH(force_ld), .CHAN_CC_SET(cc_set),
      .CHAN_CC(cc), .REG_ADDR(addr), .REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .PHASE_A(pa),
      .PHASE_B(pb), .PHASE_C(pc), .PHASE_D(pd), .CHANNEL_SELECT(sel), .ADDRESS_INVALID(inv),
      .IO_TERMINATE(term), .END_EXECUTE(endx), .PROCESSOR_STATUS_WORD_CC(swcc),
      .PROCESSOR_STATUS_WORD_CC_LOAD(swcc_ld),
      .CHAN_EXEC_CLEAR(xclr), .REG_RDATA(rdata));

   // ****************************************************************
   // Helpers
   // ****************************************************************
   // Inputs move 1 ns after the edge so no sampling race is possible
   task automatic tick(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask : tick

   task automatic tally_and_finish();
      if (fails == 0 && n_compared > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish

   task automatic give_up();
      fails++;
      tally_and_finish();
   endtask : give_up

   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("Error %s expected %h seen %h", what, exp, seen);
      end
   endtask : chk

   function automatic logic bad(input logic [2:0] a);
      return a[2] | (a[1] & a[0]);
   endfunction : bad

   function automatic logic [2:0] exp_sel(input logic [2:0] a);
      return bad(a) ? 3'h0 : 3'h1 << a[1:0];
   endfunction : exp_sel

   task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      tick(1);
      wr <= 1'b0;
   endtask : wr_reg

   // Read data stand only in the cycle after the strobe
   task automatic rd_chk(input string what, input logic [3:0] a, input logic [31:0] m, input logic [31:0] e);
      addr <= a;
      rd <= 1'b1;
      tick(1);
      rd <= 1'b0;
      chk(what, rdata & m, e);
   endtask : rd_chk

   task automatic dec(input logic [2:0] b, input logic [2:0] l, input logic ip, input logic [2:0] a);
      breg <= b;
      lus <= l;
      init_load <= ip;
      start <= 1'b1;
      tick(1);
      start <= 1'b0;
      chk("select", sel, exp_sel(a));
      chk("invalid", inv, bad(a));
      chk("terminate", term, bad(a));
      tick(1);
      chk("terminate pulse", term, 1'b0);
   endtask : dec

   task automatic wait_a();
      int i;
      for (i = 0; i < 64 && pa !== 1'b1; i++) begin
         tick(1);
      end
      if (pa !== 1'b1) give_up();
   endtask : wait_a

   // First A after a restart may be short, so the second one is measured
   task automatic ring(input logic [3:0] h);
      int i;
      run <= 1'b0;
      hi <= h;
      tick(20);
      run <= 1'b1;
      wait_a();
      for (i = 0; pa === 1'b1 && i < 32; i++) tick(1);
      wait_a();
      for (i = 0; pa === 1'b1 && i < 32; i++) tick(1);
      chk("a length", i, h);
      chk("phase b", {pd, pc, pb, pa}, 4'h2);
      tick(1);
      chk("phase c", {pd, pc, pb, pa}, 4'h4);
      tick(1);
      chk("phase d", {pd, pc, pb, pa}, 4'h8);
      tick(1);
      chk("phase a again", {pd, pc, pb, pa}, 4'h1);
   endtask : ring

   task automatic cc_load(input logic [1:0] c);
      cc <= c;
      cc_set <= 1'b1;
      tick(1);
      cc_set <= 1'b0;
      rd_chk("code latches", 4'h4, 32'h700, {21'h0, c == 2'h0, c[0], c[1], 8'h0});
   endtask : cc_load

   task automatic cc_finish(input logic [1:0] c);
      int i;
      prev = 1'b0;
      for (i = 0; i < 64 && endx !== 1'b1; i++) begin
         prev = pb & p2;
         tick(1);
      end
      if (endx !== 1'b1) give_up();
      chk("end at b with pulse 2", prev, 1'b1);
      chk("gate at c", {swcc_ld, xclr, pc}, 3'h7);
      tick(1);
      chk("gate at d", {swcc_ld, xclr, pd}, 3'h7);
      tick(1);
      chk("status word code", swcc, c);
      chk("gate closed", swcc_ld, 1'b0);
      for (i = 0; i < 64 && endx === 1'b1; i++) begin
         prev = pd;
         tick(1);
      end
      if (endx !== 1'b0) give_up();
      chk("end cleared at d", prev, 1'b1);
      chk("select cleared", sel, 3'h0);
      rd_chk("latches cleared", 4'h4, 32'h700, 32'h0);
   endtask : cc_finish

   // ****************************************************************
   // Main sequence
   // ****************************************************************
   initial begin
      int k;
      tick(6);
      chk("reset outputs", {18'h0, pa, pb, pc, pd, sel, inv, term, endx, swcc, swcc_ld, xclr}, 32'h0);
      chk("reset read data", rdata, 32'h0);
      resetn <= 1'b1;
      tick(1);
      rd_chk("ctrl reset", 4'h0, 32'hffff_ffff, 32'h0);
      wr_reg(4'h8, 32'hffff_ffff);
      rd_chk("unmapped", 4'h8, 32'hffff_ffff, 32'h0);
      wr_reg(4'h0, 32'hffff_ffff);
      rd_chk("ctrl upper bits", 4'h0, 32'hffff_ffff, 32'hf);
      // Pulses without power good must not start the ring
      run <= 1'b1;
      tick(20);
      chk("idle without power", {pd, pc, pb, pa}, 4'h0);
      pg <= 1'b1;
      ring(4'h1);
      ring(4'h3);
      run <= 1'b0;
      tick(20);
      chk("idle without pulses", {pd, pc, pb, pa}, 4'h0);
      run <= 1'b1;
      wait_a();
      pg <= 1'b0;
      tick(1);
      chk("idle on power loss", {pd, pc, pb, pa}, 4'h0);
      pg <= 1'b1;
      ring(4'h1);
      // Every address from each source; the unused source carries the complement
      for (k = 0; k < 8; k++) begin
         dec(k[2:0], ~k[2:0], 1'b0, k[2:0]);
      end
      for (k = 0; k < 8; k++) begin
         wr_reg(4'h0, {28'h0, k[2:0], 1'b1});
         dec(~k[2:0], ~k[2:0], 1'b1, k[2:0]);
      end
      wr_reg(4'h0, 32'h0);
      for (k = 0; k < 8; k++) begin
         dec(~k[2:0], k[2:0], 1'b1, k[2:0]);
      end
      init_load <= 1'b0;
      for (k = 0; k < 4; k++) begin
         dec(3'h1, 3'h0, 1'b0, 3'h1);
         cc_load(k[1:0]);
         cc_finish(k[1:0]);
      end
      // During initial load the end latch waits for the force-load latch
      init_load <= 1'b1;
      cc_load(2'h1);
      tick(40);
      chk("end held in load", endx, 1'b0);
      force_ld <= 1'b1;
      cc_finish(2'h1);
      tally_and_finish();
   end
endmodule : io_channel_common_control_bench
`default_nettype wire
